// >>> hdl/lcd_driver_i2c_write_slave.sv
// write-only two-wire bus slave front end of a segment display driver, with its display byte FIFO
// assumes clk_sys at 100 MHz; bus lines and straps are asynchronous pins
`default_nettype none

// ----------------------------------------------------------------
// display byte FIFO
// ----------------------------------------------------------------
module lcd_byte_fifo #(
    parameter int WIDTH = 15,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             reset,
    // filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr_idx;
        logic [AW-1:0]               rd_idx;
        logic [AW:0]                 count;
    } fifo_state_type;

    fifo_state_type state_reg;
    fifo_state_type state_next;
    logic           push;
    logic           pop;

    // handshakes straight from the fill count
    assign in_ready  = (state_reg.count != (AW+1)'(DEPTH));
    assign out_valid = (state_reg.count != '0);
    assign out_data  = state_reg.mem[state_reg.rd_idx];

    // next state of storage and indices
    always_comb begin
        state_next = state_reg;
        push       = in_valid && in_ready;
        pop        = out_valid && out_ready;
        if (push) begin
            state_next.mem[state_reg.wr_idx] = in_data;
            state_next.wr_idx = (state_reg.wr_idx == AW'(DEPTH-1)) ? '0 : state_reg.wr_idx + 1'b1;
        end
        if (pop) begin
            state_next.rd_idx = (state_reg.rd_idx == AW'(DEPTH-1)) ? '0 : state_reg.rd_idx + 1'b1;
        end
        if (push && !pop) begin
            state_next.count = state_reg.count + 1'b1;
        end else if (pop && !push) begin
            state_next.count = state_reg.count - 1'b1;
        end
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end
endmodule

// ----------------------------------------------------------------
// bus slave receiver
// ----------------------------------------------------------------
module lcd_driver_i2c_write_slave
    import lcd_i2c_pkg::*;
#(
    parameter int FIFO_DEPTH_P = FIFO_DEPTH
) (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       reset,
    // bus pins
    input  wire logic       scl_pin,
    input  wire logic       sda_pin,
    output logic            ack_out_pin_out,
    output logic            ack_out_pin_oe,
    // strap pins
    input  wire logic       addr_strap_pin,
    input  wire logic       subaddr_strap_bit0,
    input  wire logic       subaddr_strap_bit1,
    input  wire logic       subaddr_strap_bit2,
    // display byte stream
    output logic            disp_valid,
    input  wire logic       disp_ready,
    output logic [6:0]      disp_addr,
    output logic [7:0]      disp_data,
    // command stream and status
    output logic            cmd_valid,
    output logic [7:0]      cmd_byte,
    output logic [6:0]      data_pointer,
    output logic [2:0]      subaddr_counter,
    output logic            bus_busy
);
    typedef struct packed {
        logic       scl_s1;
        logic       scl_s2;
        logic       sda_s1;
        logic       sda_s2;
        logic [3:0] strap_s1;
        logic [3:0] strap_s2;
        logic       scl_f;
        logic       sda_f;
        logic [1:0] scl_cnt;
        logic [1:0] sda_cnt;
        phase_type  phase;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic       in_ack;
        logic       ack_want;
        logic       ack_drive;
        logic       cont;
        logic       route;
        logic [6:0] ptr;
        logic [2:0] sub_cnt;
        logic       overflow;
        logic       cmd_valid;
        logic [7:0] cmd_byte;
    } slave_state_type;

    slave_state_type         state_reg;
    slave_state_type         state_next;
    logic                    scl_rise;
    logic                    scl_fall;
    logic                    start_det;
    logic                    stop_det;
    logic                    byte_done;
    logic [7:0]              byte_in;
    logic                    sub_match;
    logic                    push_valid;
    logic                    push_ready;
    logic [FIFO_WIDTH-1:0]   push_data;
    logic [FIFO_WIDTH-1:0]   pop_data;
    logic [2:0]              own_sub;
    logic                    own_sa;

    assign own_sub = state_reg.strap_s2[2:0];
    assign own_sa  = state_reg.strap_s2[3];

    // open-drain acknowledge, only ever pulls low
    assign ack_out_pin_out = 1'b0;
    assign ack_out_pin_oe  = state_reg.ack_drive;
    assign cmd_valid       = state_reg.cmd_valid;
    assign cmd_byte        = state_reg.cmd_byte;
    assign data_pointer    = state_reg.ptr;
    assign subaddr_counter = state_reg.sub_cnt;
    assign bus_busy        = (state_reg.phase != PH_IDLE);
    assign disp_addr       = pop_data[14:8];
    assign disp_data       = pop_data[7:0];

    // receiver next state
    always_comb begin
        state_next = state_reg;
        state_next.scl_s1   = scl_pin;
        state_next.scl_s2   = state_reg.scl_s1;
        state_next.sda_s1   = sda_pin;
        state_next.sda_s2   = state_reg.sda_s1;
        state_next.strap_s1 = {addr_strap_pin, subaddr_strap_bit2, subaddr_strap_bit1, subaddr_strap_bit0};
        state_next.strap_s2 = state_reg.strap_s1;
        state_next.scl_cnt  = '0;
        state_next.sda_cnt  = '0;
        if (state_reg.scl_s2 != state_reg.scl_f) begin
            state_next.scl_cnt = state_reg.scl_cnt + 1'b1;
            if (state_reg.scl_cnt == 2'(FILTER_CYCLES - 1)) begin
                state_next.scl_f   = state_reg.scl_s2;
                state_next.scl_cnt = '0;
            end
        end
        if (state_reg.sda_s2 != state_reg.sda_f) begin
            state_next.sda_cnt = state_reg.sda_cnt + 1'b1;
            if (state_reg.sda_cnt == 2'(FILTER_CYCLES - 1)) begin
                state_next.sda_f   = state_reg.sda_s2;
                state_next.sda_cnt = '0;
            end
        end
        scl_rise  = !state_reg.scl_f && state_next.scl_f;
        scl_fall  = state_reg.scl_f && !state_next.scl_f;
        // start: data falls while clock high
        start_det = state_reg.scl_f && state_next.scl_f && state_reg.sda_f && !state_next.sda_f;
        // stop: data rises while clock high
        stop_det  = state_reg.scl_f && state_next.scl_f && !state_reg.sda_f && state_next.sda_f;
        byte_in   = {state_reg.shift[6:0], state_reg.sda_f};
        byte_done = scl_rise && (state_reg.bit_cnt == 4'd7)
                    && (state_reg.phase != PH_IDLE) && (state_reg.phase != PH_IGNORE);
        sub_match = (state_reg.sub_cnt == own_sub);
        push_valid = 1'b0;
        push_data  = {state_reg.ptr, byte_in};
        state_next.cmd_valid = 1'b0;

        if (start_det) begin
            // start or repeated start opens an address phase
            state_next.phase     = PH_ADDR;
            state_next.bit_cnt   = '0;
            state_next.in_ack    = 1'b0;
            state_next.ack_drive = 1'b0;
            state_next.ack_want  = 1'b0;
        end else if (stop_det) begin
            // back to waiting for a start
            state_next.phase     = PH_IDLE;
            state_next.bit_cnt   = '0;
            state_next.in_ack    = 1'b0;
            state_next.ack_drive = 1'b0;
        end else if (state_reg.phase != PH_IDLE && state_reg.phase != PH_IGNORE) begin
            if (scl_rise && state_reg.bit_cnt < 4'd8) begin
                state_next.shift   = byte_in;
                state_next.bit_cnt = state_reg.bit_cnt + 1'b1;
            end
            // drive from the fall after bit 8 to the fall after pulse 9
            if (scl_fall && state_reg.bit_cnt == 4'd8) begin
                if (!state_reg.in_ack) begin
                    state_next.in_ack    = 1'b1;
                    state_next.ack_drive = state_reg.ack_want;
                end else begin
                    state_next.in_ack    = 1'b0;
                    state_next.ack_drive = 1'b0;
                    state_next.bit_cnt   = '0;
                end
            end
            if (byte_done) begin
                state_next.ack_want = 1'b0;
                case (state_reg.phase)
                    PH_ADDR: begin
                        // address match on family, strap and write direction
                        if (byte_in[7:2] == ADDR_FAMILY && byte_in[ADDR_STRAP_POS] == own_sa
                            && !byte_in[ADDR_DIR_POS]) begin
                            state_next.ack_want = 1'b1;
                            state_next.phase    = PH_CTRL;
                        end else begin
                            state_next.phase = PH_IGNORE;
                        end
                    end
                    PH_CTRL: begin
                        state_next.cont     = byte_in[CTRL_CONT_POS];
                        state_next.route    = byte_in[CTRL_ROUTE_POS];
                        state_next.ack_want = 1'b1;
                        state_next.phase    = PH_PAYLOAD;
                    end
                    PH_PAYLOAD: begin
                        state_next.phase = state_reg.cont ? PH_CTRL : PH_PAYLOAD;
                        if (!state_reg.route) begin
                            state_next.ack_want  = 1'b1;
                            state_next.cmd_valid = 1'b1;
                            state_next.cmd_byte  = byte_in;
                            if (!byte_in[CMD_PTR_POS]) begin
                                state_next.ptr      = byte_in[6:0];
                                state_next.overflow = 1'b0;
                            end else if (byte_in[7:3] == CMD_DEVSEL_CODE) begin
                                state_next.sub_cnt  = byte_in[2:0];
                                state_next.overflow = 1'b0;
                            end
                        end else if (!state_reg.overflow && !(sub_match && !push_ready)) begin
                            // only the matching subaddress stores and acknowledges
                            push_valid          = sub_match;
                            state_next.ack_want = sub_match;
                            if (state_reg.ptr == PTR_LAST) begin
                                state_next.ptr     = PTR_RESET;
                                state_next.sub_cnt = state_reg.sub_cnt + 1'b1;
                                // past the last device, drop further data
                                state_next.overflow = (state_reg.sub_cnt == SUB_LAST);
                            end else begin
                                state_next.ptr = state_reg.ptr + 1'b1;
                            end
                        end
                    end
                    default: begin
                        state_next.phase = state_reg.phase;
                    end
                endcase
            end
        end
    end

    // state register, reset to idle and released
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_reg         <= '0;
            state_reg.scl_s1  <= 1'b1;
            state_reg.scl_s2  <= 1'b1;
            state_reg.sda_s1  <= 1'b1;
            state_reg.sda_s2  <= 1'b1;
            state_reg.scl_f   <= 1'b1;
            state_reg.sda_f   <= 1'b1;
            state_reg.phase   <= PH_IDLE;
            state_reg.ptr     <= PTR_RESET;
            state_reg.sub_cnt <= SUB_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // display bytes buffered toward the RAM writer
    lcd_byte_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH_P)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (push_data),
        .out_valid (disp_valid),
        .out_ready (disp_ready),
        .out_data  (pop_data)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_START_OPENS_ADDR: assert property (@(posedge clk_sys) disable iff (reset)
        start_det |=> state_reg.phase == PH_ADDR && state_reg.bit_cnt == 4'd0)
        else $error("start did not open an address phase");
    AST_STOP_IDLES: assert property (@(posedge clk_sys) disable iff (reset)
        stop_det |=> state_reg.phase == PH_IDLE && !ack_out_pin_oe)
        else $error("stop did not return to idle");
    AST_ACK_HELD_HIGH: assert property (@(posedge clk_sys) disable iff (reset)
        (ack_out_pin_oe && state_reg.scl_f && !scl_fall && !start_det && !stop_det) |=> ack_out_pin_oe)
        else $error("acknowledge released while clock high");
    AST_DRIVE_ONLY_ACK: assert property (@(posedge clk_sys) disable iff (reset)
        ack_out_pin_oe |-> state_reg.in_ack && state_reg.bit_cnt == 4'd8 && !ack_out_pin_out)
        else $error("pin driven outside an acknowledge slot");
    AST_ADDR_ACK: assert property (@(posedge clk_sys) disable iff (reset)
        (byte_done && state_reg.phase == PH_ADDR && byte_in == {ADDR_FAMILY, own_sa, 1'b0})
        |=> state_reg.ack_want && state_reg.phase == PH_CTRL)
        else $error("matching address not acknowledged");
    AST_IGNORE_SILENT: assert property (@(posedge clk_sys) disable iff (reset)
        state_reg.phase == PH_IGNORE |-> !ack_out_pin_oe && !push_valid && !state_reg.cmd_valid)
        else $error("ignored transfer produced activity");
    AST_CTRL_ACK: assert property (@(posedge clk_sys) disable iff (reset)
        (byte_done && state_reg.phase == PH_CTRL) |=> state_reg.ack_want && state_reg.phase == PH_PAYLOAD)
        else $error("control byte not acknowledged");
    AST_DISP_MATCH: assert property (@(posedge clk_sys) disable iff (reset)
        push_valid |-> state_reg.sub_cnt == own_sub && state_reg.route && !state_reg.overflow)
        else $error("display byte stored without subaddress match");
    AST_PTR_ADVANCE: assert property (@(posedge clk_sys) disable iff (reset)
        (push_valid && push_ready && state_reg.ptr != PTR_LAST) |=> state_reg.ptr == $past(state_reg.ptr) + 7'h01)
        else $error("data pointer did not advance");
    AST_OVERFLOW_NOACK: assert property (@(posedge clk_sys) disable iff (reset)
        (byte_done && state_reg.phase == PH_PAYLOAD && state_reg.route && state_reg.overflow)
        |=> !state_reg.ack_want)
        else $error("data past the end acknowledged");
    AST_PTR_LOAD: assert property (@(posedge clk_sys) disable iff (reset)
        (byte_done && state_reg.phase == PH_PAYLOAD && !state_reg.route && !byte_in[CMD_PTR_POS])
        |=> state_reg.ptr == $past(byte_in[6:0]) && cmd_valid)
        else $error("pointer load not applied");
    AST_RESET_IDLE: assert property (@(posedge clk_sys)
        $fell(reset) |-> state_reg.phase == PH_IDLE && !ack_out_pin_oe && state_reg.bit_cnt == 4'd0)
        else $error("reset left the receiver busy");
endmodule
`default_nettype wire

// >>> hdl/lcd_i2c_pkg.sv
// shared constants and types of the display driver's two-wire write slave
// assumes one system clock; bus lines arrive asynchronously on pins
`default_nettype none
package lcd_i2c_pkg;
    // ------------------------------------------------------------
    // address and byte fields
    // ------------------------------------------------------------
    localparam logic [5:0] ADDR_FAMILY     = 6'h1C;    // upper six address bits 011100
    localparam int         ADDR_STRAP_POS  = 1;        // address bit matched to the strap
    localparam int         ADDR_DIR_POS    = 0;        // direction bit, write only
    localparam int         CTRL_CONT_POS   = 7;        // continue flag in control byte
    localparam int         CTRL_ROUTE_POS  = 6;        // payload route flag in control byte
    localparam int         CMD_PTR_POS     = 7;        // zero here marks a pointer load
    localparam logic [4:0] CMD_DEVSEL_CODE = 5'h1C;    // subaddress load opcode 11100
    localparam logic [6:0] PTR_LAST        = 7'h4F;    // last display RAM address (79)
    localparam logic [2:0] SUB_LAST        = 3'h7;     // last subaddress of a cascade
    // ------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------
    localparam logic [6:0] PTR_RESET       = 7'h00;
    localparam logic [2:0] SUB_RESET       = 3'h0;
    localparam int         FILTER_CYCLES   = 2;        // samples a line must hold to pass
    localparam int         FIFO_DEPTH      = 8;
    localparam int         FIFO_WIDTH      = 15;       // pointer and display byte
    // ------------------------------------------------------------
    // receiver phases
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PH_IDLE    = 3'b000,
        PH_ADDR    = 3'b001,
        PH_CTRL    = 3'b010,
        PH_PAYLOAD = 3'b011,
        PH_IGNORE  = 3'b100
    } phase_type;
endpackage
`default_nettype wire

// >>> verif/bus_master_model.sv
// two-wire bus master model that writes bytes and samples the acknowledge slot
// assumes clk_sys paces the bit timing and sda_line is the resolved open-drain data wire
`default_nettype none
module bus_master_model (
    // clock
    input  wire logic clk_sys,
    // bus lines
    input  wire logic sda_line,
    output logic      scl_drv,
    output logic      sda_drv
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // bus timing: 12 system cycles per data bit, 24 for the acknowledge slot
    // ----------------------------------------------------------------
    // lines rest high
    initial begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic start_cond();
        sda_drv <= 1'b1;
        scl_drv <= 1'b1;
        wait_n(6);
        sda_drv <= 1'b0;
        wait_n(6);
        scl_drv <= 1'b0;
        wait_n(3);
    endtask
    // stop, then idle with both lines released
    task automatic stop_cond();
        sda_drv <= 1'b0;
        wait_n(3);
        scl_drv <= 1'b1;
        wait_n(6);
        sda_drv <= 1'b1;
        wait_n(12);
    endtask
    // msb first, data steady while clock high
    task automatic wr(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_drv <= b[i];
            wait_n(3);
            scl_drv <= 1'b1;
            wait_n(6);
            scl_drv <= 1'b0;
            wait_n(3);
        end
        // release data and read the acknowledge slot
        // long low phases around the slot let the filtered acknowledge settle
        // before the clock rises, so it never looks like a start or stop
        sda_drv <= 1'b1;
        wait_n(9);
        scl_drv <= 1'b1;
        wait_n(3);
        ack = ~sda_line;
        wait_n(3);
        scl_drv <= 1'b0;
        wait_n(9);
    endtask
endmodule
`default_nettype wire

// >>> verif/lcd_driver_i2c_write_slave_test.sv
// self-checking bench of the display driver's two-wire write slave
// assumes the design package and the bus master model are compiled before it
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; $display("BAD at %0t got %h exp %h", $time, g, e); end end
module lcd_driver_i2c_write_slave_test import lcd_i2c_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_sys    = 1'b0;
    logic       reset      = 1'b1;
    logic       strap      = 1'b0;
    logic [2:0] sub        = 3'h0;
    logic       disp_ready = 1'b0;
    logic       scl, sda_m, ack_o, ack_oe, disp_valid, cmd_valid, bus_busy;
    logic [6:0] disp_addr, data_pointer;
    logic [7:0] disp_data, cmd_byte;
    logic [2:0] subaddr_counter;
    int         n_fail, compares, n_cmd;
    // open-drain data wire with pull-up
    wire logic  sda_bus = sda_m & ~(ack_oe & ~ack_o);
    // ----------------------------------------------------------------
    // instances
    // ----------------------------------------------------------------
    bus_master_model m (.clk_sys(clk_sys), .sda_line(sda_bus), .scl_drv(scl), .sda_drv(sda_m));
    lcd_driver_i2c_write_slave dut (
        .clk_sys(clk_sys), .reset(reset), .scl_pin(scl), .sda_pin(sda_bus),
        .ack_out_pin_out(ack_o), .ack_out_pin_oe(ack_oe), .addr_strap_pin(strap),
        .subaddr_strap_bit0(sub[0]), .subaddr_strap_bit1(sub[1]), .subaddr_strap_bit2(sub[2]),
        .disp_valid(disp_valid), .disp_ready(disp_ready), .disp_addr(disp_addr), .disp_data(disp_data),
        .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .data_pointer(data_pointer),
        .subaddr_counter(subaddr_counter), .bus_busy(bus_busy));
    // clock and command pulse counter
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (cmd_valid === 1'b1) n_cmd++;
    end
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic w(input logic [7:0] b, input logic e);
        logic ack;
        m.wr(b, ack);
        `CHK(ack, e)
    endtask
    task automatic summarize();
        $display("mismatches %0d compares %0d", n_fail, compares);
        if (n_fail == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // watchdog against a hang
    initial begin
        repeat (100000) @(posedge clk_sys);
        n_fail++;
        summarize();
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (8) @(posedge clk_sys);
        `CHK({ack_oe, bus_busy, data_pointer, subaddr_counter}, 12'h000)
        m.start_cond();
        w(8'h70, 1'b1);
        `CHK(bus_busy, 1'b1)
        w(8'h80, 1'b1);
        w(8'h05, 1'b1);
        `CHK({cmd_byte, data_pointer}, 15'h0285)
        w(8'h40, 1'b1);
        w(8'hAB, 1'b1);
        `CHK({disp_valid, disp_addr, disp_data, data_pointer}, {1'b1, 7'h05, 8'hAB, 7'h06})
        m.start_cond();
        w(8'h70, 1'b1);
        m.stop_cond();
        `CHK({bus_busy, n_cmd == 1}, 2'b01)
        m.start_cond();
        w(8'h72, 1'b0);
        w(8'h80, 1'b0);
        m.start_cond();
        w(8'h71, 1'b0);
        strap <= 1'b1;
        m.start_cond();
        w(8'h72, 1'b1);
        m.stop_cond();
        strap <= 1'b0;
        // fill the byte buffer until it refuses
        m.start_cond();
        w(8'h70, 1'b1);
        w(8'h80, 1'b1);
        w(8'h00, 1'b1);
        w(8'h40, 1'b1);
        for (int i = 0; i < 8; i++) w(8'(8'h10 + i), i < 7);
        `CHK(data_pointer, 7'h07)
        m.stop_cond();
        // drain it one word at a time
        for (int i = 0; i < 8; i++) begin
            `CHK({disp_valid, disp_addr, disp_data}, (i == 0) ? 16'h85AB : {1'b1, 7'(i - 1), 8'(8'h0F + i)})
            disp_ready <= 1'b1;
            @(posedge clk_sys);
            disp_ready <= 1'b0;
            @(posedge clk_sys);
        end
        `CHK(disp_valid, 1'b0)
        m.start_cond();
        w(8'h70, 1'b1);
        w(8'h80, 1'b1);
        w(8'hE3, 1'b1);
        `CHK(subaddr_counter, 3'h3)
        w(8'h40, 1'b1);
        w(8'h55, 1'b0);
        `CHK({disp_valid, data_pointer}, 8'h08)
        sub <= 3'h7;
        m.start_cond();
        w(8'h70, 1'b1);
        w(8'h80, 1'b1);
        w(8'hE7, 1'b1);
        w(8'h80, 1'b1);
        w({1'b0, PTR_LAST}, 1'b1);
        w(8'h40, 1'b1);
        w(8'h66, 1'b1);
        w(8'h77, 1'b0);
        m.stop_cond();
        summarize();
    end
endmodule
`default_nettype wire
